/* File: ssrx_core.sv */
// module: serial receiver clock, start and frame logic with register port
//
// Added by the designer: the register addresses and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
module ssrx_core (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  reset,
  // register port
  input  wire logic [7:0]            reg_addr,
  input  wire logic [31:0]           reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic [31:0]                reg_rdata,
  // pins seen from outside and transmitter events
  input  wire ssrx_pkg::ssrx_pins_s  pins_in,
  input  wire logic                  tx_start_pulse,
  output logic                       tx_enabled,
  // driven pins
  output logic                       rx_clock_pin_o,
  output logic                       rx_clock_pin_oe,
  output logic                       rx_sync_pin_o,
  output logic                       rx_sync_pin_oe,
  // received words
  output ssrx_pkg::ssrx_word_s       word_out,
  output logic                       word_valid,
  output logic                       rx_sync_flag
);
  import ssrx_pkg::*;

  // ==========================================
  // functions

  // start condition decoder
  function automatic logic start_hit(input logic [3:0] code, input logic now_v,
                                     input logic last_v, input logic tx_ev);
    logic r;
    r = 1'b0;
    case (code)
      STA_CONT:   r = 1'b1;
      STA_TX:     r = tx_ev;
      STA_LOW:    r = ~now_v;
      STA_HIGH:   r = now_v;
      STA_FALL:   r = last_v & ~now_v;
      STA_RISE:   r = ~last_v & now_v;
      STA_CHANGE: r = last_v ^ now_v;
      STA_EDGE:   r = last_v ^ now_v;
      default:    r = 1'b0;
    endcase
    return r;
  endfunction

  // dma transfer size from word length
  function automatic logic [1:0] dma_size(input logic [4:0] len);
    logic [1:0] s;
    s = DMA_WORD;
    if (len <= LEN_BYTE_MAX) begin
      s = DMA_BYTE;
    end else if (len <= LEN_HALF_MAX) begin
      s = DMA_HALF;
    end
    return s;
  endfunction

  // ==========================================
  // registers and state
  logic [11:0]          clk_div_reg;
  ssrx_rx_clock_setup_s rx_clk_reg;
  ssrx_rx_frame_setup_s rx_frm_reg;
  logic                 rx_en_reg;
  logic                 tx_en_reg;
  logic [11:0]          div_cnt_reg;
  logic                 div_clk_reg;
  logic                 sel_q_reg;
  logic                 sync_last_reg;
  logic                 tx_pend_reg;
  ssrx_state_e          state_reg;
  logic [7:0]           dly_cnt_reg;
  logic [4:0]           bit_cnt_reg;
  logic [3:0]           word_cnt_reg;
  logic [31:0]          shift_reg;
  logic [31:0]          hold_reg;
  logic [15:0]          sync_hold_reg;
  logic [4:0]           sync_cnt_reg;
  logic                 ready_reg;
  logic                 flag_reg;
  logic [8:0]           per_cnt_reg;
  logic [4:0]           pulse_cnt_reg;
  logic                 toggle_reg;
  logic                 sync_out_reg;
  logic                 word_valid_reg;
  ssrx_word_s           word_reg;
  logic [31:0]          rdata_reg;

  // ==========================================
  // decode of the register port
  logic ctl_wr;
  logic soft_rst;
  logic rx_on_wr;
  logic rx_off_wr;
  logic rd_hold;
  logic rd_status;

  assign ctl_wr    = reg_wr && (reg_addr == OFF_CONTROL);
  assign soft_rst  = ctl_wr && reg_wdata[BIT_SW_RST];
  assign rx_off_wr = ctl_wr && reg_wdata[BIT_RX_DIS];
  assign rx_on_wr  = ctl_wr && reg_wdata[BIT_RX_EN] && !rx_off_wr;
  assign rd_hold   = reg_rd && (reg_addr == OFF_RX_HOLD);
  assign rd_status = reg_rd && (reg_addr == OFF_STATUS);

  // configuration registers, cleared only by resets
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      clk_div_reg <= 12'h000;
      rx_clk_reg  <= RESET_VALUE;
      rx_frm_reg  <= RESET_VALUE;
    end else if (soft_rst) begin
      clk_div_reg <= 12'h000;
      rx_clk_reg  <= RESET_VALUE;
      rx_frm_reg  <= RESET_VALUE;
    end else if (reg_wr) begin
      if (reg_addr == OFF_CLK_DIV) begin
        clk_div_reg <= reg_wdata[11:0];
      end
      if (reg_addr == OFF_RX_CLK) begin
        rx_clk_reg <= reg_wdata & MASK_RX_CLK;
      end
      if (reg_addr == OFF_RX_FRM) begin
        rx_frm_reg <= reg_wdata & MASK_RX_FRM;
      end
    end
  end

  // enable flags; disable only stops data handling
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rx_en_reg <= 1'b0;
      tx_en_reg <= 1'b0;
    end else if (soft_rst) begin
      rx_en_reg <= 1'b0;
      tx_en_reg <= 1'b0;
    end else if (ctl_wr) begin
      if (rx_off_wr) begin
        rx_en_reg <= 1'b0;
      end else if (rx_on_wr) begin
        rx_en_reg <= 1'b1;
      end
      if (reg_wdata[BIT_TX_DIS]) begin
        tx_en_reg <= 1'b0;
      end else if (reg_wdata[BIT_TX_EN]) begin
        tx_en_reg <= 1'b1;
      end
    end
  end

  // ==========================================
  // clock divider: half period of clk_div_reg cycles
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      div_cnt_reg <= 12'h000;
      div_clk_reg <= 1'b0;
    end else if (soft_rst || (clk_div_reg == 12'h000)) begin
      div_cnt_reg <= 12'h000;
      div_clk_reg <= 1'b0;
    end else if (div_cnt_reg >= clk_div_reg - 12'h001) begin
      div_cnt_reg <= 12'h000;
      div_clk_reg <= ~div_clk_reg;
    end else begin
      div_cnt_reg <= div_cnt_reg + 12'h001;
    end
  end

  // ==========================================
  // receive clock selection and sampling edge
  logic sel_clk;
  logic sel_rise;
  logic sel_fall;
  logic tick;

  always_comb begin
    sel_clk = 1'b0;
    if (rx_frm_reg.loopback) begin
      sel_clk = pins_in.tx_clock_pin;
    end else begin
      case (rx_clk_reg.clock_source_select)
        SRC_DIVIDED: sel_clk = div_clk_reg;
        SRC_TX_CLK:  sel_clk = pins_in.tx_clock_pin;
        SRC_PIN:     sel_clk = pins_in.rx_clock_pin;
        default:     sel_clk = 1'b0;
      endcase
    end
  end

  assign sel_rise = sel_clk && !sel_q_reg;
  assign sel_fall = !sel_clk && sel_q_reg;
  assign tick     = rx_clk_reg.clock_invert ? sel_rise : sel_fall;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sel_q_reg <= 1'b0;
    end else begin
      sel_q_reg <= sel_clk;
    end
  end

  // driven clock is the uninverted selected clock
  assign rx_clock_pin_o  = sel_q_reg;
  assign rx_clock_pin_oe = (rx_clk_reg.clock_output_mode == CKO_CONT);

  // ==========================================
  // frame sync and data sources
  logic sync_src;
  logic data_src;
  logic xfer_act;
  logic sync_now;
  logic go;

  assign rx_sync_pin_oe = (rx_frm_reg.sync_output_shape != FS_NONE) &&
                          (rx_frm_reg.sync_output_shape <= FS_TOGGLE);
  assign sync_src = rx_frm_reg.loopback ? pins_in.tx_sync_pin :
                    (rx_sync_pin_oe ? sync_out_reg : pins_in.rx_sync_pin);
  assign data_src = rx_frm_reg.loopback ? pins_in.tx_data_pin :
                    pins_in.rx_data_pin;
  assign sync_now = sync_src;
  assign xfer_act = (state_reg == ST_DELAY) || (state_reg == ST_DATA);
  assign go = tick && (state_reg == ST_WAIT) &&
              start_hit(rx_clk_reg.start_sel, sync_now, sync_last_reg,
                        tx_pend_reg || tx_start_pulse);

  // last sampled sync level and pending transmitter start
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sync_last_reg <= 1'b0;
      tx_pend_reg   <= 1'b0;
    end else if (soft_rst) begin
      sync_last_reg <= 1'b0;
      tx_pend_reg   <= 1'b0;
    end else begin
      if (tick) begin
        sync_last_reg <= sync_now;
      end
      if (tx_start_pulse) begin
        tx_pend_reg <= 1'b1; // set wins over the tick clear
      end else if (tick) begin
        tx_pend_reg <= 1'b0;
      end
    end
  end

  // sync edge flag, cleared by a status read, set wins
  logic sync_edge;
  assign sync_edge = tick && (rx_frm_reg.sync_edge_select ?
                     (sync_last_reg && !sync_now) : (!sync_last_reg && sync_now));

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      flag_reg <= 1'b0;
    end else if (soft_rst) begin
      flag_reg <= 1'b0;
    end else if (sync_edge) begin
      flag_reg <= 1'b1;
    end else if (rd_status) begin
      flag_reg <= 1'b0;
    end
  end

  // ==========================================
  // reception sequencer
  logic        last_bit;
  logic        last_word;
  logic [31:0] shift_next;

  assign last_bit  = (bit_cnt_reg == rx_frm_reg.word_length);
  assign last_word = (word_cnt_reg == rx_frm_reg.words_per_frame);

  // place the incoming bit by bit order
  always_comb begin
    shift_next = (bit_cnt_reg == 5'h00) ? 32'h00000000 : shift_reg;
    if (rx_frm_reg.bit_order) begin
      shift_next = {shift_next[30:0], data_src};
    end else begin
      shift_next[bit_cnt_reg] = data_src;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg    <= ST_OFF;
      dly_cnt_reg  <= 8'h00;
      bit_cnt_reg  <= 5'h00;
      word_cnt_reg <= 4'h0;
      shift_reg    <= 32'h00000000;
    end else if (soft_rst || !rx_en_reg) begin
      state_reg    <= ST_OFF;
      bit_cnt_reg  <= 5'h00;
      word_cnt_reg <= 4'h0;
    end else begin
      case (state_reg)
        ST_OFF: begin
          state_reg <= ST_WAIT;
        end
        ST_WAIT: begin
          if (go) begin
            bit_cnt_reg  <= 5'h00;
            word_cnt_reg <= 4'h0;
            dly_cnt_reg  <= rx_clk_reg.start_delay;
            if (rx_clk_reg.start_delay != 8'h00) begin
              state_reg <= ST_DELAY;
            end else begin
              state_reg <= ST_DATA;
            end
          end
        end
        ST_DELAY: begin
          if (tick) begin
            dly_cnt_reg <= dly_cnt_reg - 8'h01;
            if (dly_cnt_reg == 8'h01) begin
              state_reg <= ST_DATA;
            end
          end
        end
        ST_DATA: begin
          if (tick) begin
            shift_reg <= shift_next;
            if (!last_bit) begin
              bit_cnt_reg <= bit_cnt_reg + 5'h01;
            end else begin
              bit_cnt_reg <= 5'h00;
              if (!last_word) begin
                word_cnt_reg <= word_cnt_reg + 4'h1;
              end else begin
                word_cnt_reg <= 4'h0;
                if (rx_clk_reg.start_sel != STA_CONT ||
                    rx_clk_reg.start_delay != 8'h00) begin
                  state_reg <= ST_WAIT;
                end
              end
            end
          end
        end
        default: begin
          state_reg <= ST_OFF;
        end
      endcase
    end
  end

  // completed words: holding register, ready flag, output strobe
  logic word_done;
  assign word_done = tick && (state_reg == ST_DATA) && last_bit && rx_en_reg;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      hold_reg       <= 32'h00000000;
      ready_reg      <= 1'b0;
      word_valid_reg <= 1'b0;
      word_reg       <= '0;
    end else if (soft_rst) begin
      hold_reg       <= 32'h00000000;
      ready_reg      <= 1'b0;
      word_valid_reg <= 1'b0;
      word_reg       <= '0;
    end else begin
      word_valid_reg <= word_done;
      if (word_done) begin
        hold_reg      <= shift_next;
        word_reg.data <= shift_next;
        word_reg.size <= dma_size(rx_frm_reg.word_length);
        ready_reg     <= 1'b1; // set wins over the read clear
      end else if (rd_hold) begin
        ready_reg <= 1'b0;
      end
    end
  end

  // sync data bits captured during the start delay, only with the FS_NEG or FS_POS sync shape
  logic pulse_mode;
  assign pulse_mode = (rx_frm_reg.sync_output_shape == FS_NEG) ||
                      (rx_frm_reg.sync_output_shape == FS_POS);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sync_hold_reg <= 16'h0000;
      sync_cnt_reg  <= 5'h00;
    end else if (soft_rst) begin
      sync_hold_reg <= 16'h0000;
      sync_cnt_reg  <= 5'h00;
    end else if (go) begin
      sync_cnt_reg <= 5'h00;
    end else if (tick && state_reg == ST_DELAY && pulse_mode &&
                 sync_cnt_reg <= {1'b0, rx_frm_reg.sync_length}) begin
      sync_hold_reg <= {sync_hold_reg[14:0], data_src};
      sync_cnt_reg  <= sync_cnt_reg + 5'h01;
    end
  end

  // ==========================================
  // period generator and sync output shaping
  logic [8:0] per_last;
  logic       per_pulse;
  logic       sync_shape;

  assign per_last  = {rx_clk_reg.period, 1'b1};
  assign per_pulse = tick && (rx_clk_reg.period != 8'h00) && (per_cnt_reg == per_last);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      per_cnt_reg   <= 9'h000;
      pulse_cnt_reg <= 5'h00;
      toggle_reg    <= 1'b0;
    end else if (soft_rst || rx_clk_reg.period == 8'h00) begin
      per_cnt_reg   <= 9'h000;
      pulse_cnt_reg <= 5'h00;
      toggle_reg    <= soft_rst ? 1'b0 : (go ? ~toggle_reg : toggle_reg);
    end else begin
      if (tick) begin
        per_cnt_reg <= per_pulse ? 9'h000 : per_cnt_reg + 9'h001;
      end
      if (per_pulse) begin
        pulse_cnt_reg <= {1'b0, rx_frm_reg.sync_length} + 5'h01;
      end else if (tick && pulse_cnt_reg != 5'h00) begin
        pulse_cnt_reg <= pulse_cnt_reg - 5'h01;
      end
      if (go) begin
        toggle_reg <= ~toggle_reg;
      end
    end
  end

  always_comb begin
    case (rx_frm_reg.sync_output_shape)
      FS_NEG:    sync_shape = (pulse_cnt_reg == 5'h00);
      FS_POS:    sync_shape = (pulse_cnt_reg != 5'h00);
      FS_LOW:    sync_shape = !xfer_act;
      FS_HIGH:   sync_shape = xfer_act;
      FS_TOGGLE: sync_shape = toggle_reg;
      default:   sync_shape = 1'b0;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sync_out_reg <= 1'b0;
    end else begin
      sync_out_reg <= sync_shape;
    end
  end

  // ==========================================
  // read data, one cycle after the strobe
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata_reg <= 32'h00000000;
    end else if (reg_rd) begin
      case (reg_addr)
        OFF_CLK_DIV: rdata_reg <= {20'h00000, clk_div_reg};
        OFF_RX_CLK:  rdata_reg <= rx_clk_reg;
        OFF_RX_FRM:  rdata_reg <= rx_frm_reg;
        OFF_RX_HOLD: rdata_reg <= hold_reg;
        OFF_SY_HOLD: rdata_reg <= {16'h0000, sync_hold_reg};
        OFF_STATUS: begin
          rdata_reg <= 32'h00000000;
          rdata_reg[ST_BIT_READY] <= ready_reg;
          rdata_reg[ST_BIT_RX_ON] <= rx_en_reg;
          rdata_reg[ST_BIT_TX_ON] <= tx_en_reg;
          rdata_reg[ST_BIT_SYNC]  <= flag_reg;
        end
        default: rdata_reg <= 32'h00000000;
      endcase
    end else begin
      rdata_reg <= 32'h00000000;
    end
  end

  // ==========================================
  // outputs
  assign reg_rdata     = rdata_reg;
  assign rx_sync_pin_o = sync_out_reg;
  assign word_out      = word_reg;
  assign word_valid    = word_valid_reg;
  assign rx_sync_flag  = flag_reg;
  assign tx_enabled    = tx_en_reg;

endmodule
`default_nettype wire

/* File: ssrx_pkg.sv */
// package: register map, field layouts and codes of the serial receive front end
`default_nettype none
package ssrx_pkg;

  // ==========================================
  // register offsets (byte addresses)
  localparam logic [7:0] OFF_CONTROL = 8'h00;
  localparam logic [7:0] OFF_CLK_DIV = 8'h04;
  localparam logic [7:0] OFF_RX_CLK  = 8'h10;
  localparam logic [7:0] OFF_RX_FRM  = 8'h14;
  localparam logic [7:0] OFF_RX_HOLD = 8'h20;
  localparam logic [7:0] OFF_SY_HOLD = 8'h30;
  localparam logic [7:0] OFF_STATUS  = 8'h40;

  // ==========================================
  // control bit positions and writable masks
  localparam int BIT_RX_EN   = 0;
  localparam int BIT_RX_DIS  = 1;
  localparam int BIT_TX_EN   = 8;
  localparam int BIT_TX_DIS  = 9;
  localparam int BIT_SW_RST  = 15;
  localparam logic [31:0] MASK_RX_CLK = 32'hFFFF0F3F;
  localparam logic [31:0] MASK_RX_FRM = 32'h017F0FBF;
  localparam logic [31:0] RESET_VALUE = 32'h00000000;

  // status bit positions
  localparam int ST_BIT_READY = 0;
  localparam int ST_BIT_RX_ON = 1;
  localparam int ST_BIT_TX_ON = 2;
  localparam int ST_BIT_SYNC  = 3;

  // ==========================================
  // codes
  localparam logic [1:0] SRC_DIVIDED = 2'h0;
  localparam logic [1:0] SRC_TX_CLK  = 2'h1;
  localparam logic [1:0] SRC_PIN     = 2'h2;
  localparam logic [2:0] CKO_CONT    = 3'h1;
  localparam logic [3:0] STA_CONT    = 4'h0;
  localparam logic [3:0] STA_TX      = 4'h1;
  localparam logic [3:0] STA_LOW     = 4'h2;
  localparam logic [3:0] STA_HIGH    = 4'h3;
  localparam logic [3:0] STA_FALL    = 4'h4;
  localparam logic [3:0] STA_RISE    = 4'h5;
  localparam logic [3:0] STA_CHANGE  = 4'h6;
  localparam logic [3:0] STA_EDGE    = 4'h7;
  localparam logic [2:0] FS_NONE     = 3'h0;
  localparam logic [2:0] FS_NEG      = 3'h1;
  localparam logic [2:0] FS_POS      = 3'h2;
  localparam logic [2:0] FS_LOW      = 3'h3;
  localparam logic [2:0] FS_HIGH     = 3'h4;
  localparam logic [2:0] FS_TOGGLE   = 3'h5;
  localparam logic [1:0] DMA_BYTE    = 2'h0;
  localparam logic [1:0] DMA_HALF    = 2'h1;
  localparam logic [1:0] DMA_WORD    = 2'h2;
  localparam logic [4:0] LEN_BYTE_MAX = 5'h07;
  localparam logic [4:0] LEN_HALF_MAX = 5'h0F;

  // ==========================================
  // types
  typedef enum logic [1:0] {ST_OFF, ST_WAIT, ST_DELAY, ST_DATA} ssrx_state_e;

  typedef struct packed {
    logic [7:0] period;
    logic [7:0] start_delay;
    logic [3:0] rsv_hi;
    logic [3:0] start_sel;
    logic [1:0] rsv_lo;
    logic       clock_invert;
    logic [2:0] clock_output_mode;
    logic [1:0] clock_source_select;
  } ssrx_rx_clock_setup_s;

  typedef struct packed {
    logic [6:0] rsv_top;
    logic       sync_edge_select;
    logic       rsv_mid;
    logic [2:0] sync_output_shape;
    logic [3:0] sync_length;
    logic [3:0] rsv_low;
    logic [3:0] words_per_frame;
    logic       bit_order;
    logic       rsv_bit;
    logic       loopback;
    logic [4:0] word_length;
  } ssrx_rx_frame_setup_s;

  typedef struct packed {
    logic tx_clock_pin;
    logic tx_sync_pin;
    logic tx_data_pin;
    logic rx_clock_pin;
    logic rx_sync_pin;
    logic rx_data_pin;
  } ssrx_pins_s;

  typedef struct packed {
    logic [31:0] data;
    logic [1:0]  size;
  } ssrx_word_s;

endpackage
`default_nettype wire

/* File: ssrx_chk.sv */
// checker: port timing of the serial receive front end
`timescale 1ns/10ps
`default_nettype none
module ssrx_chk (
  // clock, reset and register port
  input wire logic        clk,
  input wire logic        reset,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  // outputs watched
  input wire logic        tx_enabled,
  input wire logic        rx_clock_pin_oe,
  input wire logic        rx_sync_pin_oe,
  input wire logic        word_valid
);
  import ssrx_pkg::*;
  logic        wr_reg;
  logic [7:0]  adr_reg;
  logic [31:0] dat_reg;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // ==========
  // last register write, seen one cycle on
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wr_reg <= 1'b0;
      adr_reg <= 8'h00;
      dat_reg <= 32'h00000000;
    end else begin
      wr_reg <= reg_wr;
      adr_reg <= reg_addr;
      dat_reg <= reg_wdata;
    end
  end
  // ==========
  // properties
  sequence s_ctl;
    wr_reg && adr_reg == OFF_CONTROL && !dat_reg[BIT_SW_RST];
  endsequence
  property p_tx_on;
    s_ctl ##0 (dat_reg[BIT_TX_EN] && !dat_reg[BIT_TX_DIS]) |-> tx_enabled;
  endproperty
  property p_tx_off;
    s_ctl ##0 dat_reg[BIT_TX_DIS] |-> !tx_enabled && $stable(rx_clock_pin_oe) && $stable(rx_sync_pin_oe);
  endproperty
  property p_srst;
    wr_reg && adr_reg == OFF_CONTROL && dat_reg[BIT_SW_RST] |-> ##[0:1] (!tx_enabled && !rx_sync_pin_oe);
  endproperty
  property p_cko;
    wr_reg && adr_reg == OFF_RX_CLK |-> rx_clock_pin_oe == (dat_reg[4:2] == CKO_CONT);
  endproperty
  property p_sync_output_shape;
    wr_reg && adr_reg == OFF_RX_FRM |-> rx_sync_pin_oe == (dat_reg[22:20] != FS_NONE && dat_reg[22:20] <= FS_TOGGLE);
  endproperty
  property p_div;
    reg_rd && reg_addr == OFF_CLK_DIV |=> reg_rdata[31:12] == 20'h00000;
  endproperty
  property p_rd;
    !reg_rd |=> reg_rdata == 32'h00000000;
  endproperty
  property p_word;
    word_valid |=> !word_valid [*3];
  endproperty
  a_tx_on: assert property (p_tx_on) else $error("tx enable lost");
  a_tx_off: assert property (p_tx_off) else $error("disable bad");
  a_srst: assert property (p_srst) else $error("soft reset lost");
  a_cko: assert property (p_cko) else $error("clock pin enable");
  a_sync_output_shape: assert property (p_sync_output_shape) else $error("sync pin enable");
  a_div: assert property (p_div) else $error("divider width");
  a_rd: assert property (p_rd) else $error("read data not idle");
  a_word: assert property (p_word) else $error("word too short");
endmodule
bind ssrx_core ssrx_chk u_chk (.clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .tx_enabled, .rx_clock_pin_oe, .rx_sync_pin_oe, .word_valid);
`default_nettype wire

/* File: ssrx_far.sv */
// partner: codec clocking one framed word into the receive pins
`timescale 1ns/10ps
`default_nettype none
module ssrx_far (
  // burst request
  input wire logic        go,
  input wire logic [31:0] w,
  input wire logic [5:0]  n,
  input wire logic [1:0]  d,
  // pins
  output var ssrx_pkg::ssrx_pins_s p
);
  import ssrx_pkg::*;
  int i;
  // ==========
  // bursts: clock parked low outside frames
  initial p = '0;
  always @(posedge go) begin
    #37;
    for (i = 0; i < n + d + 3; i++) begin
      p.rx_clock_pin = 1'b1;
      p.rx_sync_pin = (i == 2);
      p.rx_data_pin = (i >= d + 3) ? w[i - d - 3] : ~p.rx_data_pin;
      #230;
      p.rx_clock_pin = 1'b0;
      #230;
    end
    p.rx_sync_pin = 1'b0;
    p.rx_data_pin = ~p.rx_data_pin; // released line
  end
endmodule
`default_nettype wire

/* File: ssrx_tb.sv */
// testbench: registers, control and framed reception
`timescale 1ns/10ps
`default_nettype none
module tb;
  import ssrx_pkg::*;
  logic        clk, reset, reg_wr, reg_rd, go, tx_start_pulse, tx_enabled, word_valid;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, w, got;
  logic [5:0]  n;
  logic [1:0]  d;
  ssrx_pins_s  far_p;
  ssrx_word_s  word_out;
  int          err_total, tests_run, cyc;
  ssrx_core DUT (.clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .pins_in(far_p),
    .tx_start_pulse, .tx_enabled, .rx_clock_pin_o(), .rx_clock_pin_oe(), .rx_sync_pin_o(),
    .rx_sync_pin_oe(), .word_out, .word_valid, .rx_sync_flag());
  ssrx_far u_far (.go, .w, .n, .d, .p(far_p));
  // ==========
  // clock and hang guard
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      wrap_up;
    end
  end
  // ==========
  // tasks
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    got = reg_rdata;
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic t_regs;
    rd(OFF_CLK_DIV);
    chk(got, 32'h00000000);
    wr(OFF_CLK_DIV, 32'hFFFFFFFF);
    rd(OFF_CLK_DIV);
    chk(got, 32'h00000FFF);
    wr(OFF_RX_CLK, 32'hFFFFFFFF);
    rd(OFF_RX_CLK);
    chk(got, MASK_RX_CLK);
    wr(OFF_RX_FRM, 32'hFFFFFFFF);
    rd(8'h08);
    chk(got, 32'h00000000);
    rd(OFF_RX_FRM);
    chk(got, MASK_RX_FRM);
  endtask
  task automatic t_ctrl;
    wr(OFF_CONTROL, 32'h00000003);
    rd(OFF_STATUS);
    chk({31'h0, got[ST_BIT_RX_ON]}, 32'h0);
    wr(OFF_CONTROL, 32'h00000101);
    chk({31'h0, tx_enabled}, 32'h1);
    wr(OFF_CONTROL, 32'h00000200);
    chk({31'h0, tx_enabled}, 32'h0);
    rd(OFF_RX_CLK);
    chk(got, MASK_RX_CLK);
    wr(OFF_CONTROL, 32'h00008101);
    rd(OFF_RX_CLK);
    chk(got, 32'h00000000);
    chk({31'h0, tx_enabled}, 32'h0);
  endtask
  task automatic t_rx(input logic [4:0] len, input logic msb, input logic [1:0] dl, input logic [31:0] v);
    logic [31:0] e;
    int k;
    e = 32'h0;
    for (k = 0; k <= len; k++) e[msb ? len - k : k] = v[k];
    wr(OFF_RX_CLK, {14'h0000, dl, 16'h0502});
    wr(OFF_RX_FRM, {24'h000000, msb, 2'b00, len});
    wr(OFF_CONTROL, 32'h00000001);
    w <= v;
    n <= len + 6'h01;
    d <= dl;
    go <= 1'b1;
    for (k = 0; k < 2000 && word_valid !== 1'b1; k++) @(posedge clk) #1;
    chk(word_out.data, e);
    chk({30'h0, word_out.size}, (len <= 7) ? 32'h0 : (len <= 15) ? 32'h1 : 32'h2);
    rd(OFF_STATUS);
    chk({31'h0, got[ST_BIT_SYNC]}, 32'h1);
    chk({31'h0, got[ST_BIT_READY]}, 32'h1);
    wr(OFF_CONTROL, 32'h00000002);
    go <= 1'b0;
  endtask
  // ==========
  // main sequence
  initial begin
    reset = 1'b1;
    {reg_wr, reg_rd, go, tx_start_pulse} = 4'h0;
    {reg_addr, reg_wdata, w, n, d} = '0;
    {err_total, tests_run, cyc} = '0;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    t_regs;
    t_ctrl;
    t_rx(5'h07, 1'b0, 2'h0, 32'h000000A5);
    t_rx(5'h08, 1'b1, 2'h2, 32'h0000016C);
    t_rx(5'h1F, 1'b0, 2'h1, 32'hC3A5961E);
    wrap_up;
  end
endmodule
`default_nettype wire
